// file: hdl/dbx_extender.sv
`timescale 1ns/10ps
// Contract
// - From idle-high, a fall below 75% on either side drives both sides low, stops sensing and starts holdoff.
// - The low-impedance pulldowns stay on for 1.75 us after a falling decision, then turn off.
// - Sensing stays off until the 2.5 us holdoff ends, on clock and data alike.
// - In series mode during low holdoff each node is held at or below the hold level by the device.
// - In series mode after low holdoff, return high only when both sides release, clamping a lone released side.
// - When both sides pass the rise trigger, pull the source side up for 1.75 us and release the display side.
// - High holdoff ignores transitions, then returns to idle-high once both sides exceed 85%.
// - The data channel alone also leaves high holdoff for idle-high when either side drops below 60%.
// - Two independent channel controllers, clock and data, each bidirectional with a wired-AND.
// - Cable termination is on only for the first 1.75 us of holdoff, sensing off for all of it.
// - In series mode the cable bus and display bus are fully isolated, each on its own reference.
// - With the driver enable input low all drivers are off and the two buses run independently.
// - The driver enable input is high for normal operation and low disables all drivers.
// - In idle-high all drivers are off and sensing is active.
module dbx_extender #(
	parameter int DRIVE_CYC   = dbx_pkg::DRIVE_CYC,
	parameter int HOLDOFF_CYC = dbx_pkg::HOLDOFF_CYC
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Static controls from pins
	input  wire logic                driver_enable_in,
	input  wire logic                mode_parallel_in,
	// Comparator outputs per channel, index 0 clock, 1 data
	input  wire dbx_pkg::dbx_sense_t src_sense [2],
	input  wire dbx_pkg::dbx_sense_t disp_sense [2],
	// Driver controls per channel
	output dbx_pkg::dbx_drive_t      drive [2],
	output dbx_pkg::dbx_state_t      state_out [2]
);

	// Pins and comparators come from outside the clock domain; index 0 is enable, 1 is mode
	logic [1:0] pin_ok;
	logic [7:0] s_ok;
	logic [7:0] d_ok;

	dbx_sync3 #(.W(2)) pin_sync_u (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({mode_parallel_in, driver_enable_in}),
		.dout    (pin_ok)
	);

	dbx_sync3 #(.W(8)) src_sync_u (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({src_sense[1], src_sense[0]}),
		.dout    (s_ok)
	);

	dbx_sync3 #(.W(8)) disp_sync_u (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({disp_sense[1], disp_sense[0]}),
		.dout    (d_ok)
	);

	// Two independent controllers share nothing but the static pins
	dbx_chan #(.DRIVE_CYC(DRIVE_CYC), .HOLDOFF_CYC(HOLDOFF_CYC), .IS_DATA(1'b0)) clock_chan_u (
		.sys_clk (sys_clk),
		.rst     (rst),
		.en      (pin_ok[0]),
		.par     (pin_ok[1]),
		.src     (s_ok[3:0]),
		.disp    (d_ok[3:0]),
		.drive   (drive[0]),
		.state   (state_out[0])
	);

	dbx_chan #(.DRIVE_CYC(DRIVE_CYC), .HOLDOFF_CYC(HOLDOFF_CYC), .IS_DATA(1'b1)) data_chan_u (
		.sys_clk (sys_clk),
		.rst     (rst),
		.en      (pin_ok[0]),
		.par     (pin_ok[1]),
		.src     (s_ok[7:4]),
		.disp    (d_ok[7:4]),
		.drive   (drive[1]),
		.state   (state_out[1])
	);

endmodule

// One channel controller; clock and data differ only in the extra exit of the data channel
module dbx_chan #(
	parameter int   DRIVE_CYC   = dbx_pkg::DRIVE_CYC,
	parameter int   HOLDOFF_CYC = dbx_pkg::HOLDOFF_CYC,
	parameter logic IS_DATA     = 1'b0
) (
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Synchronised static controls
	input  wire logic                en,
	input  wire logic                par,
	// Synchronised comparator results
	input  wire dbx_pkg::dbx_sense_t src,
	input  wire dbx_pkg::dbx_sense_t disp,
	// Registered driver controls and state
	output dbx_pkg::dbx_drive_t      drive,
	output dbx_pkg::dbx_state_t      state
);

	localparam logic [dbx_pkg::CNT_W-1:0] DRV_N = dbx_pkg::CNT_W'(DRIVE_CYC);
	localparam logic [dbx_pkg::CNT_W-1:0] HLD_N = dbx_pkg::CNT_W'(HOLDOFF_CYC);

	dbx_pkg::dbx_chan_t r_r, r_nxt;

	function automatic dbx_pkg::dbx_chan_t step(
		input dbx_pkg::dbx_chan_t c,
		input dbx_pkg::dbx_sense_t s,
		input dbx_pkg::dbx_sense_t d,
		input logic en,
		input logic par,
		input logic is_data
	);
		dbx_pkg::dbx_chan_t n;
		n = c;
		n.drv = '0;
		case (c.st)
			dbx_pkg::DBX_IDLE_HIGH: begin
				n.cnt = dbx_pkg::CNT_ZERO;
				if (s.fall_trig || d.fall_trig) begin
					n.st  = dbx_pkg::DBX_FALL_HOLD;
					n.cnt = HLD_N;
				end
			end
			dbx_pkg::DBX_FALL_HOLD: begin
				n.cnt = c.cnt - 1'b1;
				if (c.cnt > HLD_N - DRV_N) begin
					n.drv.src_pulldown  = 1'b1;
					n.drv.disp_pulldown = 1'b1;
					n.drv.term_en       = 1'b1;
				end else if (!par) begin
					n.drv.src_hold  = 1'b1;
					n.drv.disp_hold = 1'b1;
				end
				if (c.cnt == 1) n.st = dbx_pkg::DBX_LOW_SENSE;
			end
			dbx_pkg::DBX_LOW_SENSE: begin
				if (s.rise_trig && d.rise_trig) begin
					n.st  = dbx_pkg::DBX_RISE_HOLD;
					n.cnt = HLD_N;
				end else if (!par) begin
					n.drv.src_hold  = s.rise_trig;
					n.drv.disp_hold = d.rise_trig;
				end
			end
			dbx_pkg::DBX_RISE_HOLD: begin
				n.cnt = c.cnt - 1'b1;
				if (c.cnt > HLD_N - DRV_N) begin
					n.drv.src_pullup = 1'b1;
					n.drv.term_en    = 1'b1;
				end
				if (c.cnt == 1) n.st = dbx_pkg::DBX_HIGH_WAIT;
			end
			dbx_pkg::DBX_HIGH_WAIT: begin
				if (s.high_ok && d.high_ok) n.st = dbx_pkg::DBX_IDLE_HIGH;
				else if (is_data && (s.low_drop || d.low_drop)) n.st = dbx_pkg::DBX_IDLE_HIGH;
			end
			default: begin
				n.st = dbx_pkg::DBX_IDLE_HIGH;
			end
		endcase
		if (!en) begin
			n.st  = dbx_pkg::DBX_IDLE_HIGH;
			n.cnt = dbx_pkg::CNT_ZERO;
			n.drv = '0;
		end
		return n;
	endfunction

	always_comb begin
		r_nxt = step(r_r, src, disp, en, par, IS_DATA);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// Source and display drivers are separate controls on separate rails
	assign drive = r_r.drv;
	assign state = r_r.st;

endmodule

// Three flops against metastability; the kept value only moves when stages two and three agree
module dbx_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Raw and filtered levels
	input  wire logic [W-1:0] din,
	output logic [W-1:0]      dout
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] mid;
		logic [W-1:0] last;
		logic [W-1:0] ok;
	} dbx_sync_t;

	dbx_sync_t r_r, r_nxt;

	always_comb begin
		r_nxt      = r_r;
		r_nxt.meta = din;
		r_nxt.mid  = r_r.meta;
		r_nxt.last = r_r.mid;
		if (r_r.mid == r_r.last) begin
			r_nxt.ok = r_r.last;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			r_r <= '0;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign dout = r_r.ok;

endmodule

// file: include/dbx_pkg.sv
package dbx_pkg;

	// Timing base
	localparam int CLK_MHZ          = 100;
	localparam int DRIVE_NS         = 1750;
	localparam int HOLDOFF_NS       = 2500;
	localparam int DRIVE_CYC        = (DRIVE_NS * CLK_MHZ) / 1000;
	localparam int HOLDOFF_CYC      = (HOLDOFF_NS * CLK_MHZ) / 1000;
	localparam int CNT_W            = 12;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

	// Channel indices
	localparam int CH_CLOCK         = 0;
	localparam int CH_DATA          = 1;

	typedef enum logic [2:0] {
		DBX_IDLE_HIGH,
		DBX_FALL_HOLD,
		DBX_LOW_SENSE,
		DBX_RISE_HOLD,
		DBX_HIGH_WAIT
	} dbx_state_t;

	// Comparator results of one side of one channel
	typedef struct packed {
		logic fall_trig;   // Below fall_trigger_level (75%)
		logic rise_trig;   // Above rise_trigger_level
		logic high_ok;     // Above 85%
		logic low_drop;    // Below 60%
	} dbx_sense_t;

	// Drive controls of one channel
	typedef struct packed {
		logic src_pulldown;
		logic src_pullup;
		logic src_hold;        // Hold at low_hold_level
		logic disp_pulldown;
		logic disp_hold;
		logic term_en;
	} dbx_drive_t;

	typedef struct packed {
		dbx_state_t       st;
		logic [CNT_W-1:0] cnt;
		dbx_drive_t       drv;
	} dbx_chan_t;

endpackage

// file: test/dbx_props.sv
`timescale 1ns/10ps
module dbx_props #(
	parameter int DRIVE_CYC   = 4,
	parameter int HOLDOFF_CYC = 6
) (
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                driver_enable_in,
	input wire logic                mode_parallel_in,
	input wire dbx_pkg::dbx_drive_t drive [2],
	input wire dbx_pkg::dbx_state_t state_out [2]
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic fh0 = state_out[0] == dbx_pkg::DBX_FALL_HOLD;
	wire logic id0 = state_out[0] == dbx_pkg::DBX_IDLE_HIGH;
	wire logic rh1 = state_out[1] == dbx_pkg::DBX_RISE_HOLD;
	property p_fall; $rose(fh0) |-> ##1 drive[0].src_pulldown && drive[0].disp_pulldown; endproperty
	a_fall: assert property (p_fall) else $error("fall without pulldowns");
	property p_pd; $rose(drive[0].src_pulldown) |-> ##DRIVE_CYC !drive[0].src_pulldown; endproperty
	a_pd: assert property (p_pd) else $error("pulldown window wrong");
	property p_hold; $rose(fh0) |=> fh0[*4]; endproperty
	a_hold: assert property (p_hold) else $error("holdoff left early");
	property p_idle; $past(id0) && id0 |-> drive[0] == '0; endproperty
	a_idle: assert property (p_idle) else $error("driver on in idle");
	property p_off; (!driver_enable_in)[*8] |-> drive[0] == '0 && drive[1] == '0; endproperty
	a_off: assert property (p_off) else $error("driver on while disabled");
	property p_rise; $rose(rh1) |-> ##1 drive[1].src_pullup && !drive[1].disp_pulldown; endproperty
	a_rise: assert property (p_rise) else $error("rise drive wrong");
	property p_ser; $fell(drive[0].src_pulldown) && fh0 && !mode_parallel_in |-> ##[0:1] drive[0].src_hold; endproperty
	a_ser: assert property (p_ser) else $error("no hold in series");
	property p_term; $rose(drive[1].term_en) |-> ##DRIVE_CYC !drive[1].term_en; endproperty
	a_term: assert property (p_term) else $error("termination window wrong");
endmodule

// file: test/dbx_bus_model.sv
`timescale 1ns/10ps
module dbx_bus_model (
	input wire logic [1:0]          src_low,
	input wire logic [1:0]          disp_low,
	input wire dbx_pkg::dbx_drive_t drv [2],
	output dbx_pkg::dbx_sense_t     s [2],
	output dbx_pkg::dbx_sense_t     d [2]
);
	logic [1:0] sl;
	logic [1:0] dl;
	// Released lines go high through their pullups
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			sl[i] = src_low[i] | drv[i].src_pulldown;
			dl[i] = disp_low[i] | drv[i].disp_pulldown;
			s[i] = '{sl[i], !sl[i], !sl[i], sl[i]};
			d[i] = '{dl[i], !dl[i], !dl[i], dl[i]};
		end
	end
endmodule

// file: test/dbx_extender_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; $display("BAD t=%0t %h %h", $time, a, b); end end
module dbx_extender_bench;
	logic                sys_clk = 0;
	logic                rst = 1;
	logic                en = 0;
	logic                mode = 1;
	logic [1:0]          sl = 0;
	logic [1:0]          dl = 0;
	int                  errors = 0;
	int                  cmp_count = 0;
	dbx_pkg::dbx_sense_t s [2];
	dbx_pkg::dbx_sense_t d [2];
	dbx_pkg::dbx_drive_t drive [2];
	dbx_pkg::dbx_state_t st [2];
	dbx_extender #(.DRIVE_CYC(4), .HOLDOFF_CYC(6)) dut_u (.sys_clk(sys_clk), .rst(rst), .driver_enable_in(en),
		.mode_parallel_in(mode), .src_sense(s), .disp_sense(d), .drive(drive), .state_out(st));
	dbx_bus_model bus_u (.src_low(sl), .disp_low(dl), .drv(drive), .s(s), .d(d));
	initial forever #5 sys_clk = ~sys_clk;
	task summarize;
		$display("checks %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task wst(input int c, input dbx_pkg::dbx_state_t w);
		for (int n = 0; st[c] !== w; n++) begin
			if (n > 300) begin
				errors++;
				summarize();
			end
			tick(1);
		end
	endtask
	// One full low and high cycle, display side keeps the bus low longest
	task tst(input int c, input logic par);
		mode = par;
		tick(8);
		sl[c] = 1;
		dl[c] = 1;
		wst(c, dbx_pkg::DBX_FALL_HOLD);
		tick(1);
		`CHK({drive[c].src_pulldown, drive[c].disp_pulldown}, 2'b11)
		`CHK(st[1-c], dbx_pkg::DBX_IDLE_HIGH)
		wst(c, dbx_pkg::DBX_LOW_SENSE);
		`CHK({drive[c].src_hold, drive[c].disp_hold}, {!par, !par})
		sl[c] = 0;
		tick(8);
		`CHK(st[c], dbx_pkg::DBX_LOW_SENSE)
		`CHK(drive[c].src_hold, !par)
		dl[c] = 0;
		wst(c, dbx_pkg::DBX_RISE_HOLD);
		tick(1);
		`CHK({drive[c].src_pullup, drive[c].disp_pulldown}, 2'b10)
		wst(c, dbx_pkg::DBX_IDLE_HIGH);
		`CHK(drive[c], 6'h0)
		$display("cycle test ch %0d mode %0d done", c, par);
	endtask
	// Data leaves high holdoff on a fresh low, clock keeps waiting for both sides high
	task tr8;
		sl = 2'b11;
		dl = 2'b11;
		wst(1, dbx_pkg::DBX_LOW_SENSE);
		sl = 0;
		dl = 0;
		wst(1, dbx_pkg::DBX_RISE_HOLD);
		sl = 2'b11;
		wst(0, dbx_pkg::DBX_HIGH_WAIT);
		tick(1);
		`CHK(st[1], dbx_pkg::DBX_IDLE_HIGH)
		`CHK(st[0], dbx_pkg::DBX_HIGH_WAIT)
		sl = 0;
		wst(0, dbx_pkg::DBX_IDLE_HIGH);
		wst(1, dbx_pkg::DBX_IDLE_HIGH);
		$display("data exit test done");
	endtask
	task tdis;
		en = 0;
		sl = 2'b11;
		tick(12);
		`CHK(st[0], dbx_pkg::DBX_IDLE_HIGH)
		`CHK(drive[1], 6'h0)
		sl = 0;
		en = 1;
		tick(8);
		$display("disable test done");
	endtask
	initial begin
		tick(10);
		rst = 0;
		`CHK(st[0], dbx_pkg::DBX_IDLE_HIGH)
		`CHK(drive[1], 6'h0)
		en = 1;
		tst(0, 0);
		tst(1, 0);
		tst(1, 1);
		tr8();
		tdis();
		summarize();
	end
endmodule
bind dbx_extender dbx_props #(.DRIVE_CYC(DRIVE_CYC), .HOLDOFF_CYC(HOLDOFF_CYC)) props_u (.sys_clk(sys_clk),
	.rst(rst), .driver_enable_in(driver_enable_in), .mode_parallel_in(mode_parallel_in), .drive(drive),
	.state_out(state_out));
